// >>> adls_lock_status.v
`timescale 1ns/1ps
`default_nettype none
`include "adls_consts.vh"

module adls_lock_status (
    input  wire        clk_i,
    input  wire        rst_i,
    // Classic Wishbone slave.
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [9:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Detector levels from the loop logic, asynchronous to clk_i.
    input  wire        fine_phase_loss_i,
    input  wire        coarse_phase_loss_i,
    input  wire        input_inactive_i,
    input  wire        freq_at_limit_i,
    input  wire        monitor_loop_freq_soft_alarm_i,
    input  wire        aux_loop_freq_soft_alarm_i,
    // Shared enables, also used by the monitor loop.
    output reg         fine_loss_en_o,
    output reg         coarse_loss_en_o,
    output reg         inactive_loss_en_o,
    output reg         limit_loss_en_o,
    // Status and interrupt.
    output reg         aux_loop_locked_o,
    output reg         monitor_loop_freq_soft_alarm_o,
    output reg         aux_loop_freq_soft_alarm_o,
    output reg         irq_o
);

    // ---------------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------------
    wire [5:0]                 det_sync;
    wire                       fine_s;
    wire                       coarse_s;
    wire                       inactive_s;
    wire                       limit_s;
    wire                       mon_alarm_s;
    wire                       aux_alarm_s;
    wire [7:0]                 reg_idx;
    wire                       bus_req;
    wire                       bus_wr;
    reg                        coarse_latch_q;
    reg                        coarse_latch_d;
    reg                        locked_d;
    reg                        mon_alarm_prev_q;
    reg                        aux_alarm_prev_q;
    reg  [`ADLS_EV_COUNT-1:0]  irq_status_q;
    reg  [`ADLS_EV_COUNT-1:0]  irq_status_d;
    reg  [`ADLS_EV_COUNT-1:0]  irq_mask_q;
    reg  [`ADLS_EV_COUNT-1:0]  event_hit;
    reg  [`ADLS_EV_COUNT-1:0]  clear_hit;
    reg  [7:0]                 rd_byte;

    // ---------------------------------------------------------------------
    // Detector input synchronisation
    // ---------------------------------------------------------------------
    // All six detector levels come from the loop domain, so they share one
    // synchroniser; a change shows here four cycles after the pin.
    // Reaction time is traded for immunity to metastability and glitches.
    adls_sync #(
        .WIDTH (6)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({aux_loop_freq_soft_alarm_i, monitor_loop_freq_soft_alarm_i,
                   freq_at_limit_i, input_inactive_i,
                   coarse_phase_loss_i, fine_phase_loss_i}),
        .sync_o  (det_sync)
    );

    assign fine_s      = det_sync[0];
    assign coarse_s    = det_sync[1];
    assign inactive_s  = det_sync[2];
    assign limit_s     = det_sync[3];
    assign mon_alarm_s = det_sync[4];
    assign aux_alarm_s = det_sync[5];

    // ---------------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------------
    // A request is taken on the first cycle of strobe; ack then blocks a
    // second take only while it is high, so a held strobe is taken again.
    // Only byte lane 0 carries register bits; a write without it is acked.
    assign reg_idx = adr_i[9:2];
    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign bus_wr  = bus_req & we_i & sel_i[0];

    // ---------------------------------------------------------------------
    // Coarse slip latch
    // ---------------------------------------------------------------------
    // The latch holds any coarse slip until the coarse enable is dropped.
    // Set and clear cannot collide: setting needs the enable high and
    // clearing needs it low.
    always @*
    begin
        coarse_latch_d = coarse_latch_q;
        if (!coarse_loss_en_o)
            coarse_latch_d = 1'b0;
        else if (coarse_s)
            coarse_latch_d = 1'b1;
    end

    // ---------------------------------------------------------------------
    // Lock combination
    // ---------------------------------------------------------------------
    // Lock is the absence of every enabled loss. Only the coarse path is
    // sticky, so a locked value never hides a live loss.
    // After a slip, software learns the live state by dropping the coarse
    // enable, reading, then restoring it; the latch clears while the enable
    // is low, and lock follows two edges after the write is taken.
    always @*
    begin
        locked_d = ~((fine_loss_en_o & fine_s)
                   | coarse_latch_q
                   | (coarse_loss_en_o & coarse_s)
                   | (inactive_loss_en_o & inactive_s)
                   | (limit_loss_en_o & limit_s));
    end

    // ---------------------------------------------------------------------
    // Status flops
    // ---------------------------------------------------------------------
    // The soft alarms are reported as plain levels; they never feed the
    // lock term, since they do not disqualify the input.
    // Lock leaves reset high, matching a loop with every loss gated off.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            coarse_latch_q                 <= 1'b0;
            aux_loop_locked_o              <= `ADLS_RST_LOCKED;
            monitor_loop_freq_soft_alarm_o <= 1'b0;
            aux_loop_freq_soft_alarm_o     <= 1'b0;
            mon_alarm_prev_q               <= 1'b0;
            aux_alarm_prev_q               <= 1'b0;
        end
        else
        begin
            coarse_latch_q                 <= coarse_latch_d;
            aux_loop_locked_o              <= locked_d;
            monitor_loop_freq_soft_alarm_o <= mon_alarm_s;
            aux_loop_freq_soft_alarm_o     <= aux_alarm_s;
            mon_alarm_prev_q               <= mon_alarm_s;
            aux_alarm_prev_q               <= aux_alarm_s;
        end
    end

    // ---------------------------------------------------------------------
    // Enable registers
    // ---------------------------------------------------------------------
    // These bits live in registers shared with the monitor loop; only the
    // bits that gate a loss indicator are kept, the rest read as zero.
    // Every enable leaves reset cleared. Software should set the inactivity
    // enable: with it off, a vanished input clock can still read as locked,
    // because the other detectors hold their last state.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fine_loss_en_o     <= `ADLS_RST_ENABLE;
            inactive_loss_en_o <= `ADLS_RST_ENABLE;
            coarse_loss_en_o   <= `ADLS_RST_ENABLE;
            limit_loss_en_o    <= `ADLS_RST_ENABLE;
            irq_mask_q         <= `ADLS_RST_IRQ_MASK;
        end
        else if (bus_wr)
        begin
            case (reg_idx)
                `ADLS_IDX_FINE_ACT_EN:
                begin
                    fine_loss_en_o     <= dat_i[`ADLS_BIT_FINE_EN];
                    inactive_loss_en_o <= dat_i[`ADLS_BIT_ACT_EN];
                end
                `ADLS_IDX_COARSE_EN:
                begin
                    coarse_loss_en_o   <= dat_i[`ADLS_BIT_COARSE_EN];
                end
                `ADLS_IDX_FREQ_LIMIT_EN:
                begin
                    limit_loss_en_o    <= dat_i[`ADLS_BIT_LIMIT_EN];
                end
                `ADLS_IDX_IRQ_MASK:
                begin
                    irq_mask_q         <= dat_i[`ADLS_EV_COUNT-1:0];
                end
                default:
                begin
                    // The status register is read-only; writes vanish.
                    irq_mask_q         <= irq_mask_q;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------------
    // Interrupt events
    // ---------------------------------------------------------------------
    // Events: lock falling, a new coarse latch, either alarm rising. A set
    // in the same cycle as a write-one clear wins, so no event is lost.
    always @*
    begin
        event_hit = {`ADLS_EV_COUNT{1'b0}};
        clear_hit = {`ADLS_EV_COUNT{1'b0}};
        event_hit[`ADLS_EV_LOCK_LOST]   = aux_loop_locked_o & ~locked_d;
        event_hit[`ADLS_EV_COARSE_SLIP] = coarse_latch_d & ~coarse_latch_q;
        event_hit[`ADLS_EV_MON_ALARM]   = mon_alarm_s & ~mon_alarm_prev_q;
        event_hit[`ADLS_EV_AUX_ALARM]   = aux_alarm_s & ~aux_alarm_prev_q;
        if (bus_wr && (reg_idx == `ADLS_IDX_IRQ_STATUS))
            clear_hit = dat_i[`ADLS_EV_COUNT-1:0];
        irq_status_d = (irq_status_q & ~clear_hit) | event_hit;
    end

    // Interrupt level is registered from the next status, so it moves on the
    // same edge as the status bit with no combinational path to the pin.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_status_q <= {`ADLS_EV_COUNT{1'b0}};
            irq_o        <= 1'b0;
        end
        else
        begin
            irq_status_q <= irq_status_d;
            irq_o        <= |(irq_status_d & irq_mask_q);
        end
    end

    // ---------------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------------
    // Unmapped indices read as zero and are still acknowledged, so a stray
    // access never hangs the bus.
    // Reads have no side effects, so polling never clears a flag.
    always @*
    begin
        rd_byte = 8'h00;
        case (reg_idx)
            `ADLS_IDX_OP_STATUS:
            begin
                rd_byte[`ADLS_BIT_AUX_LOCKED] = aux_loop_locked_o;
                rd_byte[`ADLS_BIT_MON_ALARM]  = monitor_loop_freq_soft_alarm_o;
                rd_byte[`ADLS_BIT_AUX_ALARM]  = aux_loop_freq_soft_alarm_o;
            end
            `ADLS_IDX_FINE_ACT_EN:
            begin
                rd_byte[`ADLS_BIT_FINE_EN] = fine_loss_en_o;
                rd_byte[`ADLS_BIT_ACT_EN]  = inactive_loss_en_o;
            end
            `ADLS_IDX_COARSE_EN:
                rd_byte[`ADLS_BIT_COARSE_EN] = coarse_loss_en_o;
            `ADLS_IDX_FREQ_LIMIT_EN:
                rd_byte[`ADLS_BIT_LIMIT_EN] = limit_loss_en_o;
            `ADLS_IDX_IRQ_STATUS:
                rd_byte[`ADLS_EV_COUNT-1:0] = irq_status_q;
            `ADLS_IDX_IRQ_MASK:
                rd_byte[`ADLS_EV_COUNT-1:0] = irq_mask_q;
            default:
                rd_byte = 8'h00;
        endcase
    end

    // ---------------------------------------------------------------------
    // Bus answer
    // ---------------------------------------------------------------------
    // One wait state: ack and data follow the edge that takes the request,
    // and ack drops on the next edge.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            ack_o <= bus_req;
            if (bus_req)
                dat_o <= {24'h000000, rd_byte};
        end
    end

endmodule // adls_lock_status

`default_nettype wire

// >>> adls_consts.vh
`ifndef ADLS_CONSTS_VH
`define ADLS_CONSTS_VH

// ---------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define ADLS_IDX_OP_STATUS     8'h09
`define ADLS_IDX_FREQ_LIMIT_EN 8'h4d
`define ADLS_IDX_FINE_ACT_EN   8'h73
`define ADLS_IDX_COARSE_EN     8'h74
`define ADLS_IDX_IRQ_STATUS    8'h80
`define ADLS_IDX_IRQ_MASK      8'h81

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define ADLS_BIT_AUX_LOCKED    6
`define ADLS_BIT_MON_ALARM     5
`define ADLS_BIT_AUX_ALARM     4
`define ADLS_BIT_FINE_EN       7
`define ADLS_BIT_ACT_EN        6
`define ADLS_BIT_COARSE_EN     7
`define ADLS_BIT_LIMIT_EN      7
`define ADLS_EV_LOCK_LOST      0
`define ADLS_EV_COARSE_SLIP    1
`define ADLS_EV_MON_ALARM      2
`define ADLS_EV_AUX_ALARM      3
`define ADLS_EV_COUNT          4

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define ADLS_RST_LOCKED        1'b1
`define ADLS_RST_ENABLE        1'b0
`define ADLS_RST_IRQ_MASK      4'h0

// ---------------------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------------------
`define ADLS_SYNC_STAGES       3

`endif

// >>> adls_sync.v
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser for a group of asynchronous levels. The clean
// output follows only once the second and third stages agree, which filters
// a single-cycle glitch from the detector side.
module adls_sync #(
    parameter WIDTH = 6
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] stage2_q;
    reg [WIDTH-1:0] stage3_q;

    // ---------------------------------------------------------------------
    // Synchroniser chain
    // ---------------------------------------------------------------------
    // The first stage feeds only the second stage.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q   <= {WIDTH{1'b0}};
            stage2_q <= {WIDTH{1'b0}};
            stage3_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q   <= async_i;
            stage2_q <= meta_q;
            stage3_q <= stage2_q;
        end
    end

    // ---------------------------------------------------------------------
    // Agreement filter
    // ---------------------------------------------------------------------
    // Each bit updates only when the two settled stages agree.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_bit
            always @(posedge clk_i)
            begin
                if (rst_i)
                    sync_o[g] <= 1'b0;
                else if (stage2_q[g] == stage3_q[g])
                    sync_o[g] <= stage3_q[g];
            end
        end
    endgenerate

endmodule // adls_sync

`default_nettype wire

// >>> adls_lock_status_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Lock status checker
// ----------------------------------------------------------------
// Seven cycles cover the three-stage synchroniser, its agree filter and the output flop.
module adls_lock_status_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [9:0]  adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        fine_phase_loss_i,
    input wire logic        coarse_phase_loss_i,
    input wire logic        input_inactive_i,
    input wire logic        freq_at_limit_i,
    input wire logic        monitor_loop_freq_soft_alarm_i,
    input wire logic        aux_loop_freq_soft_alarm_i,
    input wire logic        fine_loss_en_o,
    input wire logic        coarse_loss_en_o,
    input wire logic        inactive_loss_en_o,
    input wire logic        limit_loss_en_o,
    input wire logic        aux_loop_locked_o,
    input wire logic        monitor_loop_freq_soft_alarm_o,
    input wire logic        aux_loop_freq_soft_alarm_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus handshake and status read layout.
    a_ack_follows_req : assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("Ack did not follow a request.");
    a_ack_single_pulse : assert property (ack_o |-> $past(cyc_i && stb_i) ##1 !ack_o)
        else $error("Ack was not a single answered pulse.");
    a_status_unused_zero : assert property (ack_o && $past(!we_i && adr_i[9:2] == 8'h09) |-> dat_o[31:7] == 25'h0 && dat_o[3:0] == 4'h0)
        else $error("Unused status bits read nonzero.");

    // Lock combination of the four gated loss terms.
    a_gates_off_locked : assert property ((!fine_loss_en_o && !coarse_loss_en_o && !inactive_loss_en_o && !limit_loss_en_o)[*7] |-> aux_loop_locked_o)
        else $error("Lock low with every loss term disabled.");
    a_quiet_locked : assert property ((!fine_phase_loss_i && !coarse_loss_en_o && !input_inactive_i && !freq_at_limit_i)[*7] |-> aux_loop_locked_o)
        else $error("Lock low with no loss present.");
    a_loss_unlocks : assert property (((fine_loss_en_o && fine_phase_loss_i) || (inactive_loss_en_o && input_inactive_i) || (limit_loss_en_o && freq_at_limit_i))[*7] |-> !aux_loop_locked_o)
        else $error("Lock high during an enabled loss.");
    a_slip_latched : assert property ((coarse_loss_en_o && coarse_phase_loss_i)[*7] ##1 coarse_loss_en_o[*8] |-> !aux_loop_locked_o)
        else $error("Coarse slip loss did not stay latched.");

    // Soft alarm levels.
    a_mon_alarm_set : assert property (monitor_loop_freq_soft_alarm_i[*7] |-> monitor_loop_freq_soft_alarm_o)
        else $error("Monitor alarm not reported.");
    a_aux_alarm_set : assert property (aux_loop_freq_soft_alarm_i[*7] |-> aux_loop_freq_soft_alarm_o)
        else $error("Aux alarm not reported.");
    a_alarms_clear : assert property ((!monitor_loop_freq_soft_alarm_i && !aux_loop_freq_soft_alarm_i)[*7] |-> !monitor_loop_freq_soft_alarm_o && !aux_loop_freq_soft_alarm_o)
        else $error("Alarm reported while within limits.");
endmodule // adls_lock_status_checker

`default_nettype wire

// >>> test_adls_lock_status.sv
`timescale 1ns/1ps
`default_nettype none

module test_adls_lock_status;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [9:0]  adr_i = 10'h000;
    logic [31:0] dat_i = 32'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [3:0]  lanes = 4'h1;
    logic [3:0]  loss  = 4'h0;
    logic [1:0]  alarm = 2'h0;
    wire  [31:0] dat_o;
    wire         ack_o;
    wire  [3:0]  en;
    wire  [2:0]  sts;
    wire         irq_o;
    int          fails = 0;
    int          compares = 0;
    int          cycles = 0;
    logic [31:0] rd;
    logic [7:0]  idx_t [4] = '{8'h73, 8'h74, 8'h73, 8'h4d};
    logic [7:0]  msk_t [4] = '{8'h80, 8'h80, 8'h40, 8'h80};

    adls_lock_status u_adls_lock_status (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .fine_phase_loss_i(loss[0]), .coarse_phase_loss_i(loss[1]), .input_inactive_i(loss[2]),
        .freq_at_limit_i(loss[3]), .monitor_loop_freq_soft_alarm_i(alarm[0]),
        .aux_loop_freq_soft_alarm_i(alarm[1]), .fine_loss_en_o(en[0]), .coarse_loss_en_o(en[1]),
        .inactive_loss_en_o(en[2]), .limit_loss_en_o(en[3]), .aux_loop_locked_o(sts[2]),
        .monitor_loop_freq_soft_alarm_o(sts[1]), .aux_loop_freq_soft_alarm_o(sts[0]), .irq_o(irq_o)
    );

    // ----------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------------------------------
    // Free-running 40 MHz clock.
    always #12.5 clk_i = ~clk_i;

    // A hung handshake ends the run here rather than stalling forever.
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails = fails + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One classic cycle; the request holds until ack is sampled high.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= wr;
        sel_i <= lanes;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        sel_i <= 4'h0;
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string nm);
        bus(1'b0, idx, 8'h00);
        chk(nm, rd, {24'h0, exp});
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_map();
        rd_chk(8'h09, 8'h40, "status after reset");
        rd_chk(8'h74, 8'h00, "coarse enable reset");
        bus(1'b1, 8'h09, 8'hff);
        rd_chk(8'h09, 8'h40, "status after write");
        lanes = 4'h0;
        bus(1'b1, 8'h74, 8'h80);
        lanes = 4'h1;
        rd_chk(8'h74, 8'h00, "write without lane 0");
        rd_chk(8'h3c, 8'h00, "unmapped read");
    endtask

    // Each loss is first shown gated off, then enabled, then removed.
    task automatic t_losses();
        for (int i = 0; i < 4; i++)
        begin
            loss[i] <= 1'b1;
            pause(8);
            rd_chk(8'h09, 8'h40, "loss while disabled");
            bus(1'b1, idx_t[i], msk_t[i]);
            rd_chk(idx_t[i], msk_t[i], "enable readback");
            chk("enable pins", {28'h0, en}, 32'h1 << i);
            pause(8);
            rd_chk(8'h09, 8'h00, "loss while enabled");
            chk("lock pin", {31'h0, sts[2]}, 32'h0);
            loss[i] <= 1'b0;
            pause(8);
            if (i == 1)
            begin
                rd_chk(8'h09, 8'h00, "slip held low");
                bus(1'b1, 8'h74, 8'h00);
                rd_chk(8'h09, 8'h40, "lock with coarse off");
                bus(1'b1, 8'h74, 8'h80);
                pause(8);
            end
            rd_chk(8'h09, 8'h40, "lock restored");
            chk("lock pin restored", {31'h0, sts[2]}, 32'h1);
            bus(1'b1, idx_t[i], 8'h00);
        end
    endtask

    // Events from the loss scenario are checked first, then the alarm events.
    task automatic t_alarms_irq();
        rd_chk(8'h80, 8'h03, "events after losses");
        bus(1'b1, 8'h81, 8'h01);
        pause(2);
        chk("irq unmasked", {31'h0, irq_o}, 32'h1);
        bus(1'b1, 8'h80, 8'h01);
        pause(2);
        chk("irq cleared", {31'h0, irq_o}, 32'h0);
        rd_chk(8'h80, 8'h02, "one event left");
        bus(1'b1, 8'h80, 8'h02);
        bus(1'b1, 8'h81, 8'h04);
        alarm[0] <= 1'b1;
        pause(8);
        rd_chk(8'h09, 8'h60, "monitor alarm");
        chk("irq alarm", {31'h0, irq_o}, 32'h1);
        alarm[1] <= 1'b1;
        pause(8);
        rd_chk(8'h09, 8'h70, "both alarms");
        chk("status pins", {29'h0, sts}, 32'h7);
        rd_chk(8'h80, 8'h0c, "alarm events");
        alarm <= 2'h0;
        bus(1'b1, 8'h81, 8'h00);
        pause(8);
        chk("irq masked", {31'h0, irq_o}, 32'h0);
        rd_chk(8'h09, 8'h40, "alarms cleared");
        chk("alarm pins clear", {30'h0, sts[1:0]}, 32'h0);
    endtask

    // A reset in mid-run returns every register and pin to its idle value.
    task automatic t_mid_reset();
        bus(1'b1, 8'h74, 8'h80);
        bus(1'b1, 8'h81, 8'h0f);
        pause(2);
        chk("irq before reset", {31'h0, irq_o}, 32'h1);
        rst_i <= 1'b1;
        pause(2);
        rst_i <= 1'b0;
        chk("enables after reset", {28'h0, en}, 32'h0);
        chk("irq after reset", {31'h0, irq_o}, 32'h0);
        chk("lock pin after reset", {31'h0, sts[2]}, 32'h1);
        rd_chk(8'h80, 8'h00, "events after mid reset");
        rd_chk(8'h09, 8'h40, "status after mid reset");
    endtask

    // A vanished input leaves the other detectors holding, so only the
    // inactivity enable shows it as a loss of lock.
    task automatic t_no_input();
        loss[2] <= 1'b1;
        pause(8);
        rd_chk(8'h09, 8'h40, "no input, inactivity off");
        bus(1'b1, 8'h73, 8'h40);
        pause(8);
        rd_chk(8'h09, 8'h00, "no input, inactivity on");
        loss[2] <= 1'b0;
        pause(8);
        rd_chk(8'h09, 8'h40, "input back");
        bus(1'b1, 8'h73, 8'h00);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Reset for ten cycles, then run every scenario in turn.
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_map();
        t_losses();
        t_alarms_irq();
        t_mid_reset();
        t_no_input();
        tally_and_finish();
    end
endmodule // test_adls_lock_status

bind adls_lock_status adls_lock_status_checker u_adls_lock_status_checker (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .fine_phase_loss_i,
    .coarse_phase_loss_i, .input_inactive_i, .freq_at_limit_i, .monitor_loop_freq_soft_alarm_i,
    .aux_loop_freq_soft_alarm_i, .fine_loss_en_o, .coarse_loss_en_o, .inactive_loss_en_o,
    .limit_loss_en_o, .aux_loop_locked_o, .monitor_loop_freq_soft_alarm_o, .aux_loop_freq_soft_alarm_o
);

`default_nettype wire
